// ---- verilog/switch_consts.vh ----
// Constants shared by the store-and-forward switch core and its CRC engine.
// Function
// RQ1 - Frames wait in their ingress port queue; decisions start only at queue head.
// RQ2 - Check frame length limits and legal known header fields before forwarding.
// RQ3 - Compute CRC over each frame, drop it when the check sequence differs.
// RQ4 - With Layer 3 checking active, verify IP version and protocol identifier.
// RQ5 - At Layer 3, decrement the IP time-to-live of every forwarded packet.
// RQ6 - Drop packets whose time-to-live has reached zero.
// RQ7 - After changing time-to-live, recompute IP header checksum and frame check sequence.
// RQ8 - Fragment packets longer than the outgoing link MTU before sending; the core drops such packets instead when DF is set.
// RQ9 - Take lookup destination address from the leading frame bytes.
// RQ10 - Lookup gives one egress port for unicast, a port set for multicast/broadcast.
// RQ11 - Flood frames with unknown destination to all ports.
// RQ12 - Learn source address with arrival port, creating or refreshing the entry.
// RQ13 - Remove learned entries not refreshed within the aging interval.
// RQ14 - Never send a frame back out of its arrival port, flooding included.
// RQ15 - Aging is a programmable tick count; age resets when source seen again.
// RQ16 - Full table keeps valid entries; frame still forwarded or flooded.
`ifndef SWITCH_CONSTS_VH
`define SWITCH_CONSTS_VH
`define CLK_MHZ 100
`define AGE_TICK_US 1000
`define FRAME_MIN 64
`define FRAME_MAX 1518
`define LINK_MTU 1500
`define FRAG_UNIT 8
`define AGE_W 8
`define AGE_ONE 8'h01
`define AGE_MAX 8'hFF
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320
`define CRC_RESIDUE 32'hDEBB20E3
`define OFF_SA 12'h006
`define OFF_TYPE 12'h00C
`define OFF_VIHL 12'h00E
`define OFF_TLEN 12'h010
`define OFF_FRAG 12'h014
`define OFF_TTL 12'h016
`define OFF_PROTO 12'h017
`define OFF_CSUM 12'h018
`define IP_HDR_LEN 12'h014
`define IP_END 12'h022
`define MIN_DATA 12'h03C
`define FCS_LEN 12'h004
`define FCS_LAST 2'h3
`define TYPE_MIN 16'h0600
`define TYPE_IPV4 16'h0800
`define VIHL_V4 8'h45
`define PROTO_ICMP 8'h01
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11
`define FRAG_DF 16'h4000
`define FRAG_MF 16'h2000
`define FRAG_OFFS 16'h1FFF
`endif

// ---- verilog/eth_crc32.v ----
// Byte-wide Ethernet CRC-32 engine, reflected form.
`timescale 1ns/1ps
`include "switch_consts.vh"
module eth_crc32 (
  input wire sys_clk,
  input wire reset_n,
  input wire clr,
  input wire en,
  input wire [7:0] din,
  output reg [31:0] crc_r,
  output reg [31:0] crc_nxt
);
  integer i;

  always @* begin
    crc_nxt = crc_r;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_nxt[0] ^ din[i])
        crc_nxt = (crc_nxt >> 1) ^ `CRC_POLY;
      else
        crc_nxt = crc_nxt >> 1;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_r <= `CRC_INIT;
    end else if (clr) begin
      crc_r <= `CRC_INIT;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end
endmodule

// ---- verilog/store_forward_switch_core.v ----
// Store-and-forward switch core: input queues, checks, Layer 3 edit, lookup and learning.
`timescale 1ns/1ps
`include "switch_consts.vh"
module store_forward_switch_core #(
  parameter NPORTS = 4,
  parameter NENT = 16,
  parameter FRAME_MAX = `FRAME_MAX,
  parameter FRAME_MIN = `FRAME_MIN,
  parameter LINK_MTU = `LINK_MTU,
  parameter TICK_CYCLES = `AGE_TICK_US * `CLK_MHZ
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [NPORTS-1:0] rx_valid,
  input wire [8*NPORTS-1:0] rx_data,
  input wire [NPORTS-1:0] rx_last,
  output wire [NPORTS-1:0] rx_ready,
  output wire tx_valid,
  output wire [7:0] tx_data,
  output wire tx_last,
  output wire [NPORTS-1:0] tx_mask,
  input wire tx_ready,
  input wire l3_enable,
  input wire [`AGE_W-1:0] age_limit,
  output wire frame_fwd,
  output wire frame_drop
);
  localparam PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;
  localparam EW = (NENT > 1) ? $clog2(NENT) : 1;
  localparam TW = $clog2(TICK_CYCLES + 1);
  localparam [TW-1:0] TICK_LAST = TICK_CYCLES - 1;
  localparam [11:0] FRAG_DATA = ((LINK_MTU - `IP_HDR_LEN) / `FRAG_UNIT) * `FRAG_UNIT;
  localparam [12:0] FRAG_UNITS = FRAG_DATA / `FRAG_UNIT;
  localparam [11:0] MTU = LINK_MTU;
  localparam [11:0] LEN_MIN = FRAME_MIN;
  localparam [11:0] LEN_MAX = FRAME_MAX;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DECIDE = 3'h1;
  localparam [2:0] S_SEND = 3'h2;
  localparam [2:0] S_FCS = 3'h3;
  localparam [2:0] S_FREE = 3'h4;

  reg [7:0] mem [0:NPORTS*FRAME_MAX-1];
  reg [11:0] wptr_r [0:NPORTS-1];
  reg [NPORTS-1:0] held_r;
  reg [NPORTS-1:0] crc_ok_r;
  reg [NPORTS-1:0] ovf_r;
  wire [32*NPORTS-1:0] rx_crc_nxt;
  wire [NPORTS-1:0] rx_take;
  wire [NPORTS-1:0] release_p;

  reg vld_r [0:NENT-1];
  reg [47:0] mac_r [0:NENT-1];
  reg [PW-1:0] tport_r [0:NENT-1];
  reg [`AGE_W-1:0] age_r [0:NENT-1];
  reg [TW-1:0] tick_cnt_r;

  reg [2:0] st_r;
  reg [PW-1:0] cur_r;
  reg [PW-1:0] last_r;
  reg [11:0] opos_r;
  reg [11:0] ppos_r;
  reg [11:0] rem_r;
  reg [12:0] foff_r;
  reg [1:0] fcnt_r;
  reg ip_r;
  reg tx_valid_r;
  reg [7:0] tx_data_r;
  reg tx_last_r;
  reg [NPORTS-1:0] tx_mask_r;
  reg fwd_r;
  reg drop_r;

  integer p;
  integer e;
  integer i;
  integer j;
  integer k;
  integer q;
  integer t;
  integer base;
  reg [47:0] da;
  reg [47:0] sa;
  reg [15:0] etype;
  reg [15:0] tlen;
  reg [15:0] fword;
  reg [15:0] csum;
  reg [7:0] vihl;
  reg [7:0] ttl;
  reg [7:0] proto;
  reg [11:0] flen;
  reg l2_ok;
  reg is_ip;
  reg l3_ok;
  reg frame_ok;
  reg [NPORTS-1:0] fmask;
  reg hit;
  reg [PW-1:0] hport;
  reg shit;
  reg [EW-1:0] sidx;
  reg ffree;
  reg [EW-1:0] fidx;
  reg pick_ok;
  reg [PW-1:0] pick;
  reg [11:0] chunk;
  reg lastf;
  reg [11:0] dsum;
  reg [11:0] dlen;
  reg [15:0] ntl;
  reg [15:0] nfw;
  reg [15:0] ncs;
  reg [7:0] obyte;
  wire [31:0] tx_crc;
  wire adv;
  wire tick;
  wire learn;
  wire [NPORTS-1:0] self_m;
  wire [NPORTS-1:0] all_m;

  function [15:0] oc_add(input [15:0] a, input [15:0] b);
    reg [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      oc_add = s[15:0] + {15'h0000, s[16]};
    end
  endfunction

  // A frame is held until the engine frees it, so the queue holds one frame per port.
  assign rx_take = rx_valid & ~held_r;
  assign rx_ready = ~held_r;
  assign release_p = (st_r == S_FREE) ? ({{(NPORTS-1){1'b0}}, 1'b1} << cur_r) : {NPORTS{1'b0}};

  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1) begin : rx_chk
      eth_crc32 u_crc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clr(release_p[g]),
        .en(rx_take[g]),
        .din(rx_data[8*g +: 8]),
        .crc_r(),
        .crc_nxt(rx_crc_nxt[32*g +: 32])
      );
    end
  endgenerate

  always @(posedge sys_clk) begin
    for (q = 0; q < NPORTS; q = q + 1) begin
      if (rx_take[q] && wptr_r[q] < LEN_MAX)
        mem[q*FRAME_MAX + wptr_r[q]] <= rx_data[8*q +: 8]; // see RQ1
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (p = 0; p < NPORTS; p = p + 1)
        wptr_r[p] <= 12'h000;
      held_r <= {NPORTS{1'b0}};
      crc_ok_r <= {NPORTS{1'b0}};
      ovf_r <= {NPORTS{1'b0}};
    end else begin
      for (p = 0; p < NPORTS; p = p + 1) begin
        if (release_p[p]) begin
          held_r[p] <= 1'b0;
          wptr_r[p] <= 12'h000;
          ovf_r[p] <= 1'b0;
        end else if (rx_take[p]) begin
          if (wptr_r[p] < LEN_MAX)
            wptr_r[p] <= wptr_r[p] + 12'h001;
          else
            ovf_r[p] <= 1'b1;
          if (rx_last[p]) begin
            held_r[p] <= 1'b1; // see RQ1
            crc_ok_r[p] <= (rx_crc_nxt[32*p +: 32] == `CRC_RESIDUE); // see RQ3
          end
        end
      end
    end
  end

  // Round-robin over held queue heads, starting after the last port served.
  always @* begin
    pick_ok = 1'b0;
    pick = {PW{1'b0}};
    j = 0;
    for (k = NPORTS; k >= 1; k = k - 1) begin
      j = (last_r + k) % NPORTS;
      if (held_r[j]) begin
        pick_ok = 1'b1;
        pick = j[PW-1:0];
      end
    end
  end

  // Header fields are read straight from the held buffer, which stays stable until freed.
  always @* begin
    base = cur_r * FRAME_MAX;
    da = 48'h000000000000;
    sa = 48'h000000000000;
    for (i = 0; i < 6; i = i + 1) begin
      da = {da[39:0], mem[base + i]}; // see RQ9
      sa = {sa[39:0], mem[base + `OFF_SA + i]};
    end
    etype = {mem[base + `OFF_TYPE], mem[base + `OFF_TYPE + 1]};
    vihl = mem[base + `OFF_VIHL];
    tlen = {mem[base + `OFF_TLEN], mem[base + `OFF_TLEN + 1]};
    fword = {mem[base + `OFF_FRAG], mem[base + `OFF_FRAG + 1]};
    ttl = mem[base + `OFF_TTL];
    proto = mem[base + `OFF_PROTO];
    csum = {mem[base + `OFF_CSUM], mem[base + `OFF_CSUM + 1]};
    flen = wptr_r[cur_r];
    l2_ok = crc_ok_r[cur_r] && !ovf_r[cur_r] && flen >= LEN_MIN && flen <= LEN_MAX
            && etype >= `TYPE_MIN; // see RQ2 RQ3
    is_ip = l3_enable && etype == `TYPE_IPV4;
    l3_ok = !is_ip || (vihl == `VIHL_V4 && ttl > `AGE_ONE // see RQ4 RQ6
            && (proto == `PROTO_ICMP || proto == `PROTO_TCP || proto == `PROTO_UDP)
            && tlen >= {4'h0, `IP_HDR_LEN}
            && tlen + {4'h0, `OFF_VIHL} <= {4'h0, flen - `FCS_LEN}
            && !(tlen > {4'h0, MTU} && (fword & `FRAG_DF) != 16'h0000)); // see RQ8
    frame_ok = l2_ok && l3_ok;
  end

  always @* begin
    hit = 1'b0;
    hport = {PW{1'b0}};
    shit = 1'b0;
    sidx = {EW{1'b0}};
    ffree = 1'b0;
    fidx = {EW{1'b0}};
    for (e = NENT - 1; e >= 0; e = e - 1) begin
      if (vld_r[e] && mac_r[e] == da) begin
        hit = 1'b1;
        hport = tport_r[e];
      end
      if (vld_r[e] && mac_r[e] == sa) begin
        shit = 1'b1;
        sidx = e[EW-1:0];
      end
      if (!vld_r[e]) begin
        ffree = 1'b1;
        fidx = e[EW-1:0];
      end
    end
  end

  assign all_m = {NPORTS{1'b1}};
  assign self_m = {{(NPORTS-1){1'b0}}, 1'b1} << cur_r;

  always @* begin
    if (da[40] || !hit)
      fmask = all_m & ~self_m; // see RQ10 RQ11 RQ14
    else
      fmask = ({{(NPORTS-1){1'b0}}, 1'b1} << hport) & ~self_m; // see RQ10 RQ14
  end

  // Per-fragment header edits; an unfragmented packet is one fragment holding all data.
  always @* begin
    lastf = rem_r <= FRAG_DATA;
    chunk = lastf ? rem_r : FRAG_DATA; // see RQ8
    dsum = `IP_END + chunk;
    if (!ip_r)
      dlen = flen - `FCS_LEN;
    else if (dsum < `MIN_DATA)
      dlen = `MIN_DATA;
    else
      dlen = dsum;
    ntl = {4'h0, `IP_HDR_LEN + chunk};
    nfw = (fword & ~(`FRAG_OFFS | `FRAG_MF)) | (lastf ? (fword & `FRAG_MF) : `FRAG_MF)
          | ({3'h0, foff_r} & `FRAG_OFFS);
    ncs = ~oc_add(oc_add(oc_add(oc_add(oc_add(oc_add(~csum, ~tlen), ntl), ~fword), nfw),
          ~{ttl, proto}), {ttl - `AGE_ONE, proto}); // see RQ7
    if (ip_r && opos_r < `IP_END) begin
      case (opos_r)
        `OFF_TLEN: obyte = ntl[15:8];
        `OFF_TLEN + 12'h001: obyte = ntl[7:0];
        `OFF_FRAG: obyte = nfw[15:8];
        `OFF_FRAG + 12'h001: obyte = nfw[7:0];
        `OFF_TTL: obyte = ttl - `AGE_ONE; // see RQ5
        `OFF_CSUM: obyte = ncs[15:8];
        `OFF_CSUM + 12'h001: obyte = ncs[7:0];
        default: obyte = mem[base + opos_r];
      endcase
    end else if (ip_r && opos_r < dsum) begin
      obyte = mem[base + ppos_r];
    end else if (ip_r) begin
      obyte = 8'h00;
    end else begin
      obyte = mem[base + opos_r];
    end
  end

  assign adv = !tx_valid_r || tx_ready;

  eth_crc32 u_tx_crc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clr(st_r == S_DECIDE || (st_r == S_FCS && adv && fcnt_r == `FCS_LAST)),
    .en(st_r == S_SEND && adv),
    .din(obyte),
    .crc_r(tx_crc),
    .crc_nxt()
  );

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= S_IDLE;
      cur_r <= {PW{1'b0}};
      last_r <= {PW{1'b0}};
      opos_r <= 12'h000;
      ppos_r <= 12'h000;
      rem_r <= 12'h000;
      foff_r <= 13'h0000;
      fcnt_r <= 2'h0;
      ip_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_last_r <= 1'b0;
      tx_mask_r <= {NPORTS{1'b0}};
      fwd_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      fwd_r <= 1'b0;
      drop_r <= 1'b0;
      if (tx_ready) begin
        tx_valid_r <= 1'b0;
        tx_last_r <= 1'b0;
      end
      case (st_r)
        S_IDLE: begin
          if (pick_ok) begin
            cur_r <= pick;
            st_r <= S_DECIDE; // see RQ1
          end
        end
        S_DECIDE: begin
          if (frame_ok && fmask != {NPORTS{1'b0}}) begin
            tx_mask_r <= fmask;
            ip_r <= is_ip;
            opos_r <= 12'h000;
            ppos_r <= `IP_END;
            rem_r <= tlen[11:0] - `IP_HDR_LEN;
            foff_r <= fword[12:0];
            fwd_r <= 1'b1;
            st_r <= S_SEND;
          end else begin
            drop_r <= 1'b1; // see RQ2 RQ3 RQ4 RQ6 RQ14
            st_r <= S_FREE;
          end
        end
        S_SEND: begin
          if (adv) begin
            tx_valid_r <= 1'b1;
            tx_data_r <= obyte;
            tx_last_r <= 1'b0;
            opos_r <= opos_r + 12'h001;
            if (ip_r && opos_r >= `IP_END && opos_r < dsum)
              ppos_r <= ppos_r + 12'h001;
            if (opos_r == dlen - 12'h001) begin
              fcnt_r <= 2'h0;
              st_r <= S_FCS;
            end
          end
        end
        S_FCS: begin
          if (adv) begin
            tx_valid_r <= 1'b1;
            tx_data_r <= ~tx_crc[8*fcnt_r +: 8]; // see RQ7
            tx_last_r <= (fcnt_r == `FCS_LAST);
            fcnt_r <= fcnt_r + 2'h1;
            if (fcnt_r == `FCS_LAST) begin
              if (ip_r && !lastf) begin
                rem_r <= rem_r - chunk; // see RQ8
                foff_r <= foff_r + FRAG_UNITS;
                opos_r <= 12'h000;
                st_r <= S_SEND;
              end else begin
                st_r <= S_FREE;
              end
            end
          end
        end
        S_FREE: begin
          last_r <= cur_r;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Multicast sources are never learned, since they cannot be a unicast destination.
  assign learn = (st_r == S_DECIDE) && l2_ok && !sa[40];
  assign tick = (tick_cnt_r == TICK_LAST);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= {TW{1'b0}};
      for (t = 0; t < NENT; t = t + 1) begin
        vld_r[t] <= 1'b0;
        mac_r[t] <= 48'h000000000000;
        tport_r[t] <= {PW{1'b0}};
        age_r[t] <= {`AGE_W{1'b0}};
      end
    end else begin
      tick_cnt_r <= tick ? {TW{1'b0}} : tick_cnt_r + {{(TW-1){1'b0}}, 1'b1};
      // The age sum is one bit wider so a saturated age still expires.
      for (t = 0; t < NENT; t = t + 1) begin
        if (tick && vld_r[t]) begin
          if (age_limit != {`AGE_W{1'b0}}
              && {1'b0, age_r[t]} + {1'b0, `AGE_ONE} >= {1'b0, age_limit})
            vld_r[t] <= 1'b0; // see RQ13 RQ15
          else if (age_r[t] != `AGE_MAX)
            age_r[t] <= age_r[t] + `AGE_ONE; // see RQ15
        end
      end
      if (learn && shit) begin
        vld_r[sidx] <= 1'b1; // see RQ12
        tport_r[sidx] <= cur_r;
        age_r[sidx] <= {`AGE_W{1'b0}}; // see RQ15
      end else if (learn && ffree) begin
        vld_r[fidx] <= 1'b1; // see RQ12 RQ16
        mac_r[fidx] <= sa;
        tport_r[fidx] <= cur_r;
        age_r[fidx] <= {`AGE_W{1'b0}};
      end
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign tx_last = tx_last_r;
  assign tx_mask = tx_mask_r;
  assign frame_fwd = fwd_r;
  assign frame_drop = drop_r;
endmodule

// ---- bench/switch_core_checker.sv ----
// Port-level assertions for the store-and-forward switch core.
`timescale 1ns/1ps
module switch_core_checker #(
  parameter NPORTS = 4
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [NPORTS-1:0] rx_valid,
  input wire [NPORTS-1:0] rx_last,
  input wire [NPORTS-1:0] rx_ready,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_last,
  input wire [NPORTS-1:0] tx_mask,
  input wire tx_ready,
  input wire frame_fwd,
  input wire frame_drop
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last) && $stable(tx_mask);
  endproperty
  a_hold: assert property (p_hold) else $error("egress byte changed while stalled");
  property p_no_self;
    tx_valid |-> tx_mask != {NPORTS{1'b1}};
  endproperty
  a_no_self: assert property (p_no_self) else $error("egress set holds every port");
  property p_pulse;
    (frame_fwd || frame_drop) |=> !frame_fwd && !frame_drop;
  endproperty
  a_pulse: assert property (p_pulse) else $error("decision pulse longer than one cycle");
  property p_excl;
    !(frame_fwd && frame_drop);
  endproperty
  a_excl: assert property (p_excl) else $error("frame both forwarded and dropped");
  property p_fwd_tx;
    frame_fwd |-> tx_mask != {NPORTS{1'b0}} ##1 tx_valid;
  endproperty
  a_fwd_tx: assert property (p_fwd_tx) else $error("forward without egress start");
  property p_fell;
    $fell(rx_ready[0]) |-> $past(rx_valid[0] && rx_last[0]);
  endproperty
  a_fell: assert property (p_fell) else $error("port held without a last byte");
  // A decision must follow within 3 to 1000 cycles after the last byte enters the queue.
  property p_decide;
    rx_valid[0] && rx_last[0] && rx_ready[0] |-> ##[3:1000] (frame_fwd || frame_drop);
  endproperty
  a_decide: assert property (p_decide) else $error("no decision for a queued frame");
  property p_stay;
    $fell(rx_ready[0]) |-> !rx_ready[0] until (frame_fwd || frame_drop);
  endproperty
  a_stay: assert property (p_stay) else $error("queue released before decision");
  property p_last;
    tx_last |-> tx_valid;
  endproperty
  a_last: assert property (p_last) else $error("frame end without valid byte");
  c_fwd: cover property (frame_fwd);
  c_drop: cover property (frame_drop);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule
bind store_forward_switch_core switch_core_checker #(.NPORTS(NPORTS)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_last(rx_last),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_mask(tx_mask), .tx_ready(tx_ready), .frame_fwd(frame_fwd), .frame_drop(frame_drop));

// ---- bench/eth_node_sink.sv ----
// Model of the attached nodes receiving egress frames, with optional stalling.
`timescale 1ns/1ps
module eth_node_sink (
  input wire sys_clk,
  input wire slow,
  input wire tx_valid,
  input wire [7:0] tx_data,
  output reg tx_ready
);
  reg [7:0] cap [0:4095];
  integer nb = 0;
  initial tx_ready = 1'b1;
  // Slow mode accepts every other cycle so the core must hold its byte.
  always @(posedge sys_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid === 1'b1 && tx_ready) begin
      cap[nb] <= tx_data;
      nb <= nb + 1;
    end
  end
endmodule

// ---- bench/tb_store_forward_switch_core.sv ----
// Self-checking testbench for the store-and-forward switch core.
`timescale 1ns/1ps
module tb_store_forward_switch_core;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [3:0] rx_valid = 4'h0;
  reg [31:0] rx_data = 32'h0;
  reg [3:0] rx_last = 4'h0;
  reg l3_enable = 1'b0;
  reg [7:0] age_limit = 8'h00;
  reg slow = 1'b0;
  wire [3:0] rx_ready;
  wire [3:0] tx_mask;
  wire tx_valid, tx_last, tx_ready, frame_fwd, frame_drop;
  wire [7:0] tx_data;
  integer miscompares = 0;
  integer total_checks = 0;
  integer j;
  integer lasts = 0;
  integer base, lbase;
  reg [7:0] fr [0:79];
  reg [7:0] ex [0:79];
  reg [3:0] mask_seen = 4'h0;
  reg fwd_seen = 1'b0;
  reg drop_seen = 1'b0;
  always #5 sys_clk = ~sys_clk;
  // Two table slots make the full table reachable; a short MTU makes 80-byte packets split.
  store_forward_switch_core #(.NENT(2), .TICK_CYCLES(16), .LINK_MTU(52)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_mask(tx_mask), .tx_ready(tx_ready), .l3_enable(l3_enable),
    .age_limit(age_limit), .frame_fwd(frame_fwd), .frame_drop(frame_drop));
  eth_node_sink sink (.sys_clk(sys_clk), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  always @(posedge sys_clk) begin
    if (frame_fwd === 1'b1) begin
      fwd_seen <= 1'b1;
      mask_seen <= tx_mask;
    end
    if (frame_drop === 1'b1)
      drop_seen <= 1'b1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_last === 1'b1)
      lasts <= lasts + 1;
  end
  task finish_test;
    begin
      $display("total_checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task seal(input integer n);
    integer i, b;
    reg [31:0] c;
    begin
      c = 32'hFFFFFFFF;
      for (i = 0; i < n - 4; i = i + 1) begin
        c = c ^ {24'h000000, ex[i]};
        for (b = 0; b < 8; b = b + 1)
          c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      end
      c = ~c;
      for (i = 0; i < 4; i = i + 1)
        ex[n - 4 + i] = c[8*i +: 8];
    end
  endtask
  task put(input integer n);
    integer i;
    begin
      seal(n);
      for (i = 0; i < 80; i = i + 1)
        fr[i] = ex[i];
    end
  endtask
  // A nonzero ttl builds an IPv4/UDP packet with total length 46.
  task mk(input [7:0] da, input [7:0] sa, input integer n, input [7:0] ttl);
    integer i;
    begin
      for (i = 0; i < 80; i = i + 1)
        ex[i] = 8'h00;
      ex[0] = da;
      ex[6] = sa;
      ex[12] = ttl != 8'h00 ? 8'h08 : 8'h88;
      ex[13] = ttl != 8'h00 ? 8'h00 : 8'hB5;
      if (ttl != 8'h00) begin
        ex[14] = 8'h45;
        ex[17] = 8'h2E;
        ex[22] = ttl;
        ex[23] = 8'h11;
        ex[24] = 8'h10;
      end
      put(n);
    end
  endtask
  // The last egress byte may still wait on a stalled sink after the queue is freed.
  task send(input integer p, input integer n);
    integer i, k;
    begin
      fwd_seen = 1'b0;
      drop_seen = 1'b0;
      base = sink.nb;
      lbase = lasts;
      for (i = 0; i < n; i = i + 1) begin
        @(negedge sys_clk);
        rx_valid[p] = 1'b1;
        rx_data[8*p +: 8] = fr[i];
        rx_last[p] = (i == n - 1);
      end
      @(negedge sys_clk);
      rx_valid = 4'h0;
      rx_last = 4'h0;
      for (k = 0; k < 3000 && !(rx_ready[p] === 1'b1 && (fwd_seen || drop_seen)); k = k + 1)
        @(negedge sys_clk);
      if (k == 3000) begin
        miscompares = miscompares + 1;
        finish_test;
      end
      repeat (4) @(negedge sys_clk);
    end
  endtask
  task run(input integer p, input integer n, input fwd, input [3:0] mask);
    integer i;
    begin
      send(p, n);
      check({fwd_seen, drop_seen}, {fwd, !fwd});
      check(lasts - lbase, fwd);
      if (fwd) begin
        check(mask_seen, mask);
        check(sink.nb - base, n);
        for (i = 0; i < n; i = i + 1)
          check(sink.cap[base + i], ex[i]);
      end
    end
  endtask
  // A 62-byte packet over a 52-byte MTU leaves as 32 and 10 data bytes.
  task t_frag;
    integer i;
    begin
      l3_enable = 1'b1;
      mk(8'h10, 8'h20, 80, 8'h05);
      ex[17] = 8'h3E;
      for (i = 0; i < 42; i = i + 1)
        ex[34 + i] = i + 1;
      put(80);
      send(3, 80);
      check(mask_seen, 4'h1);
      check(lasts - lbase, 2);
      check(sink.nb - base, 134);
      ex[17] = 8'h34;
      ex[20] = 8'h20;
      ex[22] = 8'h04;
      ex[24] = 8'hF1;
      ex[25] = 8'h09;
      seal(70);
      for (i = 0; i < 70; i = i + 1)
        check(sink.cap[base + i], ex[i]);
      ex[17] = 8'h1E;
      ex[20] = 8'h00;
      ex[21] = 8'h04;
      ex[24] = 8'h11;
      ex[25] = 8'h1C;
      for (i = 34; i < 60; i = i + 1)
        ex[i] = i < 44 ? i - 1 : 8'h00;
      seal(64);
      for (i = 0; i < 64; i = i + 1)
        check(sink.cap[base + 70 + i], ex[i]);
      mk(8'h10, 8'h20, 80, 8'h05);
      ex[17] = 8'h3E;
      ex[20] = 8'h40;
      put(80);
      run(3, 80, 1'b0, 4'h0);
      l3_enable = 1'b0;
    end
  endtask
  task t_learn;
    begin
      mk(8'h40, 8'h10, 64, 8'h00);
      run(0, 64, 1'b1, 4'hE);
      mk(8'h10, 8'h20, 64, 8'h00);
      slow = 1'b1;
      run(1, 64, 1'b1, 4'h1);
      slow = 1'b0;
      mk(8'h41, 8'h20, 64, 8'h00);
      run(1, 64, 1'b1, 4'hD);
      mk(8'h10, 8'h30, 64, 8'h00);
      run(0, 64, 1'b0, 4'h0);
      mk(8'h30, 8'h20, 64, 8'h00);
      run(2, 64, 1'b1, 4'hB);
    end
  endtask
  task t_checks;
    begin
      mk(8'h10, 8'h20, 64, 8'h00);
      fr[20] = fr[20] ^ 8'h01;
      run(2, 64, 1'b0, 4'h0);
      mk(8'h10, 8'h20, 60, 8'h00);
      run(3, 60, 1'b0, 4'h0);
      ex[12] = 8'h05;
      put(64);
      run(3, 64, 1'b0, 4'h0);
    end
  endtask
  task t_l3;
    begin
      l3_enable = 1'b1;
      for (j = 0; j < 4; j = j + 1) begin
        mk(8'h10, 8'h20, 64, 8'h05);
        ex[23] = j == 0 ? 8'h01 : j == 1 ? 8'h06 : j == 2 ? 8'h11 : 8'h02;
        put(64);
        ex[22] = 8'h04;
        ex[24] = 8'h11;
        seal(64);
        run(3, 64, j < 3, 4'h1);
      end
      mk(8'h10, 8'h20, 64, 8'h01);
      run(3, 64, 1'b0, 4'h0);
      ex[14] = 8'h46;
      ex[22] = 8'h05;
      put(64);
      run(3, 64, 1'b0, 4'h0);
      l3_enable = 1'b0;
    end
  endtask
  task t_age;
    begin
      age_limit = 8'h02;
      repeat (100) @(negedge sys_clk);
      mk(8'h10, 8'h20, 64, 8'h00);
      run(2, 64, 1'b1, 4'hB);
    end
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    check(rx_ready, 4'hF);
    check(tx_valid, 1'b0);
    reset_n = 1'b1;
    t_learn;
    t_checks;
    t_l3;
    t_frag;
    t_age;
    finish_test;
  end
endmodule
